// ---- twi_ctrl.sv ----
// two-wire bus controller with its software register set
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps

// What this block does
// - control bit 6 enables the whole controller
// - control bit 5 starts a master START
// - control bit 4 sends a STOP
// - hardware sets interrupt flag on each bus state except F8h
// - acknowledge bit clear gives not-acknowledge when receiving
// - acknowledge bit set pulls data low in slot when receiving
// - acknowledge bit gates own and general-call address
// - acknowledge bit ignored as master transmitter
// - bits 7,1,0 select the master clock rate
// - data register holds byte, bit 0 direction
// - status holds code in 7:3, zeros below
// - status reads F8h after reset
// - own address in bits 7:1, resets FEh
// - own-address bit 0 enables general call
// - illegal START/STOP when not master gives 00h and releases
module twi_ctrl #(
	parameter int RATE_BASE = 4
) (
	// clock and reset
	input  wire logic                       clock_i,
	input  wire logic                       rst_i,
	// register port
	input  wire logic [7:0]                 addr_i,
	input  wire logic [twi_pkg::REG_W-1:0]  wdata_i,
	input  wire logic                       wr_i,
	input  wire logic                       rd_i,
	output logic      [twi_pkg::REG_W-1:0]  rdata_o,
	// bus pins, open drain
	input  wire logic                       scl_i,
	output logic                            scl_o,
	output logic                            scl_oe_o,
	input  wire logic                       sda_i,
	output logic                            sda_o,
	output logic                            sda_oe_o,
	// interrupt
	output logic                            irq_o
);
	import twi_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [2:0]       rate_r, rate_nxt;
	logic             en_r, en_nxt;
	logic             sta_r, sta_nxt;
	logic             sto_r, sto_nxt;
	logic             si_r, si_nxt;
	logic             aa_r, aa_nxt;
	logic [7:0]       own_r, own_nxt;
	logic [7:0]       sh_r, sh_nxt;
	logic [7:0]       code_r, code_nxt;
	logic [IRQ_W-1:0] ist_r, ist_nxt;
	logic [IRQ_W-1:0] imsk_r, imsk_nxt;
	twi_mode_t        mode_r, mode_nxt;
	twi_mst_t         ms_r, ms_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [3:0]       bit_r, bit_nxt;
	logic             abyte_r, abyte_nxt;
	logic             ack_r, ack_nxt;
	logic             gcall_r, gcall_nxt;
	logic             rep_r, rep_nxt;
	logic             busy_r, busy_nxt;
	logic             mst_r, mst_nxt;
	logic             mlow_r, mlow_nxt;
	logic             sda_r, sda_nxt;
	logic             scl_r, scl_nxt;
	logic             irq_r, irq_nxt;
	logic [7:0]       rdata_r, rdata_nxt;
	logic             scl_s1, scl_s2, scl_d;
	logic             sda_s1, sda_s2, sda_d;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	logic [CNT_W-1:0] half;
	logic             half_end;
	logic             rise, fall, start_det, stop_det;
	logic             tx, match, hw_si, err, wr_ctrl;
	logic [IRQ_W-1:0] ist_clr;

	assign scl_o    = 1'h0;
	assign sda_o    = 1'h0;
	assign scl_oe_o = scl_r;
	assign sda_oe_o = sda_r;
	assign irq_o    = irq_r;
	assign rdata_o  = rdata_r;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			scl_s1 <= 1'h1;
			scl_s2 <= 1'h1;
			scl_d  <= 1'h1;
			sda_s1 <= 1'h1;
			sda_s2 <= 1'h1;
			sda_d  <= 1'h1;
		end else begin
			scl_s1 <= scl_i;
			scl_s2 <= scl_s1;
			scl_d  <= scl_s2;
			sda_s1 <= sda_i;
			sda_s2 <= sda_s1;
			sda_d  <= sda_s2;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		rate_nxt  = rate_r;
		en_nxt    = en_r;
		sta_nxt   = sta_r;
		sto_nxt   = sto_r;
		aa_nxt    = aa_r;
		own_nxt   = own_r;
		sh_nxt    = sh_r;
		code_nxt  = code_r;
		imsk_nxt  = imsk_r;
		mode_nxt  = mode_r;
		ms_nxt    = ms_r;
		cnt_nxt   = cnt_r;
		bit_nxt   = bit_r;
		abyte_nxt = abyte_r;
		ack_nxt   = ack_r;
		gcall_nxt = gcall_r;
		rep_nxt   = rep_r;
		busy_nxt  = busy_r;
		mst_nxt   = mst_r;
		mlow_nxt  = mlow_r;
		sda_nxt   = sda_r;
		hw_si     = 1'h0;
		err       = 1'h0;
		// the sequencer needs at least four cycles per half so the bit engine sees each fall
		half      = CNT_W'(RATE_BASE) << rate_r;
		half_end  = (cnt_r == half - CNT_W'(1));
		rise      = scl_s2 & ~scl_d;
		fall      = ~scl_s2 & scl_d;
		start_det = scl_s2 & scl_d & sda_d & ~sda_s2;
		stop_det  = scl_s2 & scl_d & ~sda_d & sda_s2;
		tx        = (mode_r == MD_MTX) || (mode_r == MD_STX);
		match     = aa_r && ((sh_r[7:1] == own_r[7:1]) || (own_r[B_GC] && sh_r == 8'h00));
		wr_ctrl   = wr_i && (addr_i == ADDR_CTRL);

		if (start_det) begin
			busy_nxt = 1'h1;
		end
		if (stop_det) begin
			busy_nxt = 1'h0;
		end

		// data and acknowledge bits change only while the clock is low and nothing is pending
		if (mode_r != MD_IDLE && !si_r && !scl_s2) begin
			if (bit_r != BIT_LAST) begin
				sda_nxt = tx & ~sh_r[7];
			end else if (mode_r == MD_ADDR) begin
				sda_nxt = match;
			end else begin
				sda_nxt = !tx && aa_r;
			end
		end

		// master sequencer
		case (ms_r)
			MS_IDLE: begin
				cnt_nxt = '0;
				if (sto_r && !si_r) begin
					sto_nxt = 1'h0;
				end
				if (en_r && sta_r && !busy_r && !si_r && mode_r == MD_IDLE) begin
					sda_nxt = 1'h1;
					mst_nxt = 1'h1;
					rep_nxt = 1'h0;
					ms_nxt  = MS_START;
				end
			end
			MS_START: begin
				cnt_nxt = cnt_r + CNT_W'(1);
				if (half_end) begin
					cnt_nxt   = '0;
					mlow_nxt  = 1'h1;
					hw_si     = 1'h1;
					code_nxt  = rep_r ? SC_RSTART : SC_START;
					mode_nxt  = MD_MTX;
					abyte_nxt = 1'h1;
					bit_nxt   = BIT_PRE;
					ms_nxt    = MS_LOW;
				end
			end
			MS_LOW: begin
				if (si_r) begin
					cnt_nxt = '0;
				end else if (sto_r && bit_r == BIT_NONE) begin
					sda_nxt  = 1'h1;
					mode_nxt = MD_IDLE;
					ms_nxt   = MS_STOP;
				end else if (sta_r && bit_r == BIT_NONE) begin
					sda_nxt  = 1'h0;
					mode_nxt = MD_IDLE;
					ms_nxt   = MS_RSTA;
				end else begin
					cnt_nxt = cnt_r + CNT_W'(1);
					if (half_end) begin
						cnt_nxt  = '0;
						mlow_nxt = 1'h0;
						ms_nxt   = MS_HIGH;
					end
				end
			end
			MS_HIGH, MS_STOPH, MS_RSTH: begin
				// a slave stretching the clock holds the count at zero
				cnt_nxt = scl_s2 ? cnt_r + CNT_W'(1) : '0;
				if (scl_s2 && half_end) begin
					cnt_nxt = '0;
					if (ms_r == MS_HIGH) begin
						mlow_nxt = 1'h1;
						ms_nxt   = MS_LOW;
					end else if (ms_r == MS_STOPH) begin
						sda_nxt  = 1'h0;
						sto_nxt  = 1'h0;
						mst_nxt  = 1'h0;
						code_nxt = SC_IDLE;
						ms_nxt   = MS_IDLE;
					end else begin
						sda_nxt = 1'h1;
						rep_nxt = 1'h1;
						ms_nxt  = MS_START;
					end
				end
			end
			MS_STOP, MS_RSTA: begin
				cnt_nxt = cnt_r + CNT_W'(1);
				if (half_end) begin
					cnt_nxt  = '0;
					mlow_nxt = 1'h0;
					ms_nxt   = (ms_r == MS_STOP) ? MS_STOPH : MS_RSTH;
				end
			end
			default: begin
				ms_nxt = MS_IDLE;
			end
		endcase

		// bit engine: sample on clock rise
		if (mode_r != MD_IDLE && rise) begin
			if (bit_r != BIT_LAST) begin
				sh_nxt = {sh_r[6:0], sda_s2};
				if (mst_r && tx && sh_r[7] && !sda_s2) begin
					hw_si    = 1'h1;
					code_nxt = SC_ARB;
					mode_nxt = MD_IDLE;
					ms_nxt   = MS_IDLE;
					mst_nxt  = 1'h0;
					mlow_nxt = 1'h0;
					sda_nxt  = 1'h0;
				end
			end else begin
				ack_nxt = ~sda_s2;
			end
		end

		// bit engine: byte ends on the fall after the acknowledge slot
		if (mode_r != MD_IDLE && fall) begin
			if (bit_r != BIT_LAST) begin
				bit_nxt = bit_r + 4'h1;
			end else begin
				bit_nxt = BIT_NONE;
				hw_si   = 1'h1;
				case (mode_r)
					MD_ADDR: begin
						if (match) begin
							gcall_nxt = (sh_r == 8'h00);
							mode_nxt  = sh_r[0] ? MD_STX : MD_SRX;
							if (sh_r[0]) begin
								code_nxt = SC_SR_OWN;
							end else begin
								code_nxt = (sh_r == 8'h00) ? SC_SW_GC : SC_SW_OWN;
							end
						end else begin
							hw_si    = 1'h0;
							mode_nxt = MD_IDLE;
						end
					end
					MD_MTX: begin
						if (abyte_r) begin
							abyte_nxt = 1'h0;
							if (sh_r[0]) begin
								code_nxt = ack_r ? SC_AR_ACK : SC_AR_NAK;
								mode_nxt = ack_r ? MD_MRX : MD_MTX;
							end else begin
								code_nxt = ack_r ? SC_AW_ACK : SC_AW_NAK;
							end
						end else begin
							code_nxt = ack_r ? SC_DT_ACK : SC_DT_NAK;
						end
					end
					MD_MRX: begin
						code_nxt = ack_r ? SC_DR_ACK : SC_DR_NAK;
					end
					MD_SRX: begin
						if (gcall_r) begin
							code_nxt = ack_r ? SC_GR_ACK : SC_GR_NAK;
						end else begin
							code_nxt = ack_r ? SC_SR_ACK : SC_SR_NAK;
						end
						mode_nxt = ack_r ? MD_SRX : MD_IDLE;
					end
					MD_STX: begin
						code_nxt = ack_r ? SC_ST_ACK : SC_ST_NAK;
						mode_nxt = ack_r ? MD_STX : MD_IDLE;
					end
					default: begin
						mode_nxt = MD_IDLE;
					end
				endcase
			end
		end

		// conditions seen on the bus while not mastering it
		if (!mst_r && (start_det || stop_det)) begin
			if ((mode_r == MD_SRX || mode_r == MD_STX) && bit_r == BIT_NONE) begin
				hw_si    = 1'h1;
				code_nxt = SC_SLV_END;
			end else if (mode_r != MD_IDLE && bit_r != BIT_NONE) begin
				hw_si    = 1'h1;
				err      = 1'h1;
				code_nxt = SC_BUS_ERR;
				sda_nxt  = 1'h0;
			end
			mode_nxt = MD_IDLE;
			bit_nxt  = BIT_NONE;
			if (start_det && !err && en_r) begin
				mode_nxt = MD_ADDR;
				bit_nxt  = BIT_PRE;
			end
		end

		// software writes
		if (wr_ctrl) begin
			rate_nxt = {wdata_i[B_RATE2], wdata_i[B_RATE1], wdata_i[B_RATE0]};
			en_nxt   = wdata_i[B_EN];
			sta_nxt  = wdata_i[B_STA];
			sto_nxt  = wdata_i[B_STO];
			aa_nxt   = wdata_i[B_AA];
		end
		if (wr_i && addr_i == ADDR_DATA) begin
			sh_nxt = wdata_i;
		end
		if (wr_i && addr_i == ADDR_OWN) begin
			own_nxt = wdata_i;
		end
		if (wr_i && addr_i == ADDR_IRQ_MSK) begin
			imsk_nxt = wdata_i[IRQ_W-1:0];
		end

		// disabled controller drops every bus activity
		if (!en_nxt) begin
			mode_nxt = MD_IDLE;
			ms_nxt   = MS_IDLE;
			mst_nxt  = 1'h0;
			mlow_nxt = 1'h0;
			sda_nxt  = 1'h0;
			cnt_nxt  = '0;
			bit_nxt  = BIT_NONE;
		end

		// hardware set wins over a software clear in the same cycle
		si_nxt  = hw_si || (si_r && !(wr_ctrl && !wdata_i[B_SI]));
		ist_clr = (wr_i && addr_i == ADDR_IRQ_ST) ? wdata_i[IRQ_W-1:0] : '0;
		ist_nxt = (ist_r & ~ist_clr) | {err, hw_si};
		irq_nxt = |(ist_nxt & imsk_nxt);
		scl_nxt = en_nxt && (mlow_nxt || (si_nxt && (mode_nxt == MD_SRX || mode_nxt == MD_STX)));

		rdata_nxt = '0;
		if (rd_i) begin
			case (addr_i)
				ADDR_CTRL:    rdata_nxt = {rate_r[2], en_r, sta_r, sto_r, si_r, aa_r, rate_r[1:0]};
				ADDR_STAT:    rdata_nxt = {code_r[7:3], 3'h0};
				ADDR_DATA:    rdata_nxt = sh_r;
				ADDR_OWN:     rdata_nxt = own_r;
				ADDR_IRQ_ST:  rdata_nxt = {{(REG_W - IRQ_W){1'h0}}, ist_r};
				ADDR_IRQ_MSK: rdata_nxt = {{(REG_W - IRQ_W){1'h0}}, imsk_r};
				default:      rdata_nxt = '0;
			endcase
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rate_r  <= 3'h0;
			en_r    <= 1'h0;
			sta_r   <= 1'h0;
			sto_r   <= 1'h0;
			si_r    <= 1'h0;
			aa_r    <= 1'h0;
			own_r   <= RST_OWN;
			sh_r    <= 8'h00;
			code_r  <= SC_IDLE;
			ist_r   <= '0;
			imsk_r  <= '0;
			mode_r  <= MD_IDLE;
			ms_r    <= MS_IDLE;
			cnt_r   <= '0;
			bit_r   <= BIT_NONE;
			abyte_r <= 1'h0;
			ack_r   <= 1'h0;
			gcall_r <= 1'h0;
			rep_r   <= 1'h0;
			busy_r  <= 1'h0;
			mst_r   <= 1'h0;
			mlow_r  <= 1'h0;
			sda_r   <= 1'h0;
			scl_r   <= 1'h0;
			irq_r   <= 1'h0;
			rdata_r <= 8'h00;
		end else begin
			rate_r  <= rate_nxt;
			en_r    <= en_nxt;
			sta_r   <= sta_nxt;
			sto_r   <= sto_nxt;
			si_r    <= si_nxt;
			aa_r    <= aa_nxt;
			own_r   <= own_nxt;
			sh_r    <= sh_nxt;
			code_r  <= code_nxt;
			ist_r   <= ist_nxt;
			imsk_r  <= imsk_nxt;
			mode_r  <= mode_nxt;
			ms_r    <= ms_nxt;
			cnt_r   <= cnt_nxt;
			bit_r   <= bit_nxt;
			abyte_r <= abyte_nxt;
			ack_r   <= ack_nxt;
			gcall_r <= gcall_nxt;
			rep_r   <= rep_nxt;
			busy_r  <= busy_nxt;
			mst_r   <= mst_nxt;
			mlow_r  <= mlow_nxt;
			sda_r   <= sda_nxt;
			scl_r   <= scl_nxt;
			irq_r   <= irq_nxt;
			rdata_r <= rdata_nxt;
		end
	end

endmodule

// ---- twi_pkg.sv ----
// constants, register map and state types of the two-wire bus controller
package twi_pkg;

	// ----------------------------------------
	// register map and widths
	// ----------------------------------------
	localparam int         REG_W        = 8;
	localparam int         CNT_W        = 10;
	localparam logic [7:0] ADDR_CTRL    = 8'h93;
	localparam logic [7:0] ADDR_STAT    = 8'h94;
	localparam logic [7:0] ADDR_DATA    = 8'h95;
	localparam logic [7:0] ADDR_OWN     = 8'h96;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h97;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h98;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int B_RATE2 = 7;
	localparam int B_EN    = 6;
	localparam int B_STA   = 5;
	localparam int B_STO   = 4;
	localparam int B_SI    = 3;
	localparam int B_AA    = 2;
	localparam int B_RATE1 = 1;
	localparam int B_RATE0 = 0;
	localparam int B_GC    = 0;
	localparam int IRQ_W   = 2;
	localparam int IRQ_SI  = 0;
	localparam int IRQ_ERR = 1;

	// ----------------------------------------
	// reset values and counts
	// ----------------------------------------
	localparam logic [7:0] RST_OWN  = 8'hFE;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic [3:0] BIT_NONE = 4'h0;
	// the clock fall that follows a START wraps this to BIT_NONE, so it is not counted as a bit
	localparam logic [3:0] BIT_PRE  = 4'hF;

	// ----------------------------------------
	// bus state codes
	// ----------------------------------------
	localparam logic [7:0] SC_BUS_ERR = 8'h00;
	localparam logic [7:0] SC_START   = 8'h08;
	localparam logic [7:0] SC_RSTART  = 8'h10;
	localparam logic [7:0] SC_AW_ACK  = 8'h18;
	localparam logic [7:0] SC_AW_NAK  = 8'h20;
	localparam logic [7:0] SC_DT_ACK  = 8'h28;
	localparam logic [7:0] SC_DT_NAK  = 8'h30;
	localparam logic [7:0] SC_ARB     = 8'h38;
	localparam logic [7:0] SC_AR_ACK  = 8'h40;
	localparam logic [7:0] SC_AR_NAK  = 8'h48;
	localparam logic [7:0] SC_DR_ACK  = 8'h50;
	localparam logic [7:0] SC_DR_NAK  = 8'h58;
	localparam logic [7:0] SC_SW_OWN  = 8'h60;
	localparam logic [7:0] SC_SW_GC   = 8'h70;
	localparam logic [7:0] SC_SR_ACK  = 8'h80;
	localparam logic [7:0] SC_SR_NAK  = 8'h88;
	localparam logic [7:0] SC_GR_ACK  = 8'h90;
	localparam logic [7:0] SC_GR_NAK  = 8'h98;
	localparam logic [7:0] SC_SLV_END = 8'hA0;
	localparam logic [7:0] SC_SR_OWN  = 8'hA8;
	localparam logic [7:0] SC_ST_ACK  = 8'hB8;
	localparam logic [7:0] SC_ST_NAK  = 8'hC0;
	localparam logic [7:0] SC_IDLE    = 8'hF8;

	// ----------------------------------------
	// state types
	// ----------------------------------------
	typedef enum logic [2:0] {MD_IDLE, MD_ADDR, MD_MTX, MD_MRX, MD_STX, MD_SRX} twi_mode_t;
	typedef enum logic [2:0] {MS_IDLE, MS_START, MS_LOW, MS_HIGH, MS_STOP, MS_STOPH, MS_RSTA, MS_RSTH} twi_mst_t;

endpackage

// ---- twi_ctrl_monitor.sv ----
// port-level property checker of the two-wire controller
`timescale 1ns/1ps
module twi_ctrl_monitor #(
	parameter int RATE_BASE = 4
) (
	// clock and reset
	input wire logic                      clock_i,
	input wire logic                      rst_i,
	// register port
	input wire logic [7:0]                addr_i,
	input wire logic [twi_pkg::REG_W-1:0] wdata_i,
	input wire logic                      wr_i,
	input wire logic                      rd_i,
	input wire logic [twi_pkg::REG_W-1:0] rdata_o,
	// bus pins and interrupt
	input wire logic                      scl_i,
	input wire logic                      scl_o,
	input wire logic                      scl_oe_o,
	input wire logic                      sda_i,
	input wire logic                      sda_o,
	input wire logic                      sda_oe_o,
	input wire logic                      irq_o
);
	import twi_pkg::*;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// -------------------------
	// sequences
	// -------------------------
	sequence s_own_wr_rd;
		wr_i && addr_i == ADDR_OWN ##2 rd_i && addr_i == ADDR_OWN;
	endsequence
	sequence s_ctl_wr_rd;
		wr_i && addr_i == ADDR_CTRL ##2 rd_i && addr_i == ADDR_CTRL;
	endsequence
	sequence s_start_req;
		wr_i && addr_i == ADDR_CTRL && wdata_i[B_EN] && wdata_i[B_STA] && scl_i && sda_i && !irq_o;
	endsequence
	// -------------------------
	// properties
	// -------------------------
	property p_stat_low;
		rd_i && addr_i == ADDR_STAT |=> rdata_o[2:0] == 3'h0;
	endproperty
	a_stat_low: assert property (p_stat_low) else $error("status low bits not zero");
	property p_own_rb;
		s_own_wr_rd |=> rdata_o == $past(wdata_i, 3);
	endproperty
	a_own_rb: assert property (p_own_rb) else $error("own address readback wrong");
	property p_ctl_rb;
		s_ctl_wr_rd |=> (rdata_o & 8'hC7) == ($past(wdata_i, 3) & 8'hC7);
	endproperty
	a_ctl_rb: assert property (p_ctl_rb) else $error("rate or enable bits lost");
	property p_dis;
		wr_i && addr_i == ADDR_CTRL && !wdata_i[B_EN] |-> ##[1:3] (!scl_oe_o && !sda_oe_o);
	endproperty
	a_dis: assert property (p_dis) else $error("disabled controller drives bus");
	property p_start;
		s_start_req |-> ##[1:12] sda_oe_o ##[1:12] scl_oe_o;
	endproperty
	a_start: assert property (p_start) else $error("start condition not sent");
	property p_irq_hold;
		!wr_i ##1 (!wr_i && irq_o) |=> irq_o;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without software");
	property p_od_low;
		(scl_oe_o || sda_oe_o) |-> (!scl_o && !sda_o);
	endproperty
	a_od_low: assert property (p_od_low) else $error("pin driven high");
	property p_rst_idle;
		$fell(rst_i) |-> (rdata_o == 8'h00 && !scl_oe_o && !sda_oe_o && !irq_o);
	endproperty
	a_rst_idle: assert property (p_rst_idle) else $error("outputs active after reset");
endmodule

bind twi_ctrl twi_ctrl_monitor #(.RATE_BASE(RATE_BASE)) twi_ctrl_monitor_i (.clock_i(clock_i), .rst_i(rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_i),
	.scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));

// ---- twi_slave_model.sv ----
// behavioural slave on the two-wire bus
`timescale 1ns/1ps
module twi_slave_model #(
	parameter logic [6:0] ADR = 7'h3C
) (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_pull_o,
	output logic [7:0] last_o,
	output logic      stop_o
);
	logic [7:0] sh;
	int         cnt;
	logic       sel;
	logic       first;
	initial begin
		{sda_pull_o, stop_o, sel, first} = 4'h0;
		cnt = 0;
		sh = 8'h00;
		last_o = 8'h00;
	end
	always @(negedge sda_i) if (scl_i) begin
		cnt = 0;
		first = 1'b1;
		stop_o = 1'b0;
	end
	always @(posedge sda_i) if (scl_i) begin
		stop_o = 1'b1;
		sel = 1'b0;
	end
	always @(posedge scl_i) if (cnt < 8) begin
		sh = {sh[6:0], sda_i};
		cnt = cnt + 1;
	end
	// ack drives only across the ninth clock; released data rises by pull-up
	always @(negedge scl_i) begin
		if (cnt == 9) begin
			sda_pull_o = 1'b0;
			cnt = 0;
		end else if (cnt == 8) begin
			if (first)
				sel = (sh[7:1] == ADR) && !sh[0];
			else
				last_o = sh;
			first = 1'b0;
			sda_pull_o = sel;
			cnt = 9;
		end
	end
endmodule

// ---- twi_ctrl_bench.sv ----
// self-checking bench of the two-wire controller as bus master
`timescale 1ns/1ps
module twi_ctrl_bench;
	import twi_pkg::*;
	localparam logic [6:0] SLV = 7'h3C;
	logic       clock_i, rst_i, wr_i, rd_i;
	logic [7:0] addr_i, wdata_i, rdata_o, rx_byte, got;
	logic       scl_o, scl_oe_o, sda_o, sda_oe_o, irq_o, sda_pull, stop_seen, scl_w, sda_w;
	int         n_errors, compares, cycles;
	// open-drain wires with pull-ups
	assign scl_w = !scl_oe_o;
	assign sda_w = !(sda_oe_o || sda_pull);
	twi_ctrl #(.RATE_BASE(4)) twi_ctrl_i (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
	twi_slave_model #(.ADR(SLV)) twi_slave_model_i (.scl_i(scl_w), .sda_i(sda_w), .sda_pull_o(sda_pull),
		.last_o(rx_byte), .stop_o(stop_seen));
	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end
	// -------------------------
	// tasks
	// -------------------------
	task automatic conclude();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#10 got = rdata_o;
	endtask
	task automatic wait_irq();
		for (int i = 0; i < 400 && irq_o !== 1'b1; i++) @(posedge clock_i) #1;
		chk("irq", 8'h01, {7'h00, irq_o});
	endtask
	task automatic poll(input logic [7:0] code);
		int i;
		i = 0;
		do rd(ADDR_STAT); while (got !== code && ++i < 100);
		chk("status", code, got);
	endtask
	// loads the data, then clears the event so the next one is seen as a fresh rise
	task automatic step(input logic [7:0] d, input logic [7:0] ctl, input logic [7:0] code);
		wr(ADDR_DATA, d);
		wr(ADDR_IRQ_ST, 8'h01);
		wr(ADDR_CTRL, ctl);
		wait_irq();
		rd(ADDR_STAT);
		chk("code", code, got);
	endtask
	task automatic stop_step(input logic [7:0] ctl);
		wr(ADDR_IRQ_ST, 8'h01);
		wr(ADDR_CTRL, ctl);
		poll(SC_IDLE);
		rd(ADDR_CTRL);
		chk("sto si", 8'h00, got & 8'h18);
		chk("stop", 8'h01, {7'h00, stop_seen});
	endtask
	// -------------------------
	// sequence of tests
	// -------------------------
	initial begin
		{rst_i, wr_i, rd_i} = 3'h4;
		{addr_i, wdata_i, got} = 24'h0;
		{n_errors, compares, cycles} = 0;
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		rd(ADDR_CTRL);
		chk("control", 8'h00, got);
		rd(ADDR_STAT);
		chk("status", 8'hF8, got);
		@(posedge clock_i) #10;
		chk("rdata idle", 8'h00, rdata_o);
		rd(ADDR_OWN);
		chk("own", RST_OWN, got);
		rd(8'h99);
		chk("unmapped", 8'h00, got);
		wr(ADDR_STAT, 8'h00);
		rd(ADDR_STAT);
		chk("status ro", 8'hF8, got);
		wr(ADDR_OWN, 8'hA5);
		rd(ADDR_OWN);
		chk("own", 8'hA5, got);
		wr(ADDR_IRQ_MSK, 8'h03);
		rd(ADDR_IRQ_MSK);
		chk("mask", 8'h03, got);
		wr(ADDR_CTRL, 8'hA3);
		rd(ADDR_CTRL);
		chk("rate", 8'h83, got & 8'hC7);
		repeat (10) begin
			rd(ADDR_STAT);
			chk("disabled", 8'hF8, got);
		end
		chk("disabled irq", 8'h00, {7'h00, irq_o});
		wr(ADDR_CTRL, 8'h64);
		wait_irq();
		poll(SC_START);
		rd(ADDR_CTRL);
		chk("si", 8'h08, got & 8'h08);
		step({SLV, 1'b0}, 8'h44, SC_AW_ACK);
		step(8'h5A, 8'h44, SC_DT_ACK);
		chk("rx", 8'h5A, rx_byte);
		stop_step(8'h54);
		wr(ADDR_IRQ_MSK, 8'h00);
		wr(ADDR_CTRL, 8'h60);
		poll(SC_START);
		chk("masked", 8'h00, {7'h00, irq_o});
		rd(ADDR_IRQ_ST);
		chk("irq st", 8'h01, got & 8'h01);
		wr(ADDR_IRQ_MSK, 8'h01);
		wait_irq();
		step({7'h11, 1'b0}, 8'h40, SC_AW_NAK);
		stop_step(8'h50);
		conclude();
	end
endmodule
